/* File: logic/jmr_bank.sv */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// - Each channel's high-byte error register reads bits 15 to 8 of its 16-bit error count.
// - Channels 1 to 16 and channel 0 each have such a register, and all read zero after reset.
// - Config bit 1 picks manual periods ended by the stop bit (0) or one-second periods (1).
// - In manual mode (config bit 1 clear), a 0-to-1 change of config bit 2 loads the current positive and negative peaks.
// - Config bit 0 selects the measurement bandwidth passed to the jitter front end.
// - The 12-bit positive peak reads as bits 7 to 0 in the low and 11 to 8 in the high register.
// - The peak result is overwritten at the end of every round, manual or automatic.
// - Config bits 7 to 3 are reserved and read zero, and the register resets to zero.
// - The negative peak register pair holds the peak in sixteenths of a unit interval.
module jmr_bank
	import jmr_pkg::*;
#(
	parameter int          NUM_CH      = 16,             // Line channels besides channel 0
	parameter int unsigned AUTO_CYCLES = JMR_AUTO_CYCLES // Cycles per automatic period
) (
	input  wire logic                     clk_in,               // System clock
	input  wire logic                     rst_in,               // Asynchronous reset, high
	input  wire logic                     ce_in,                // Clock enable
	input  wire logic [JMR_ADDR_W-1:0]    addr_in,              // Register address
	input  wire logic [7:0]               wdata_in,             // Write data
	input  wire logic                     wr_in,                // Write strobe
	input  wire logic                     rd_in,                // Read strobe
	output logic      [7:0]               rdata_out,            // Read data, cycle after strobe
	input  wire logic [(NUM_CH+1)*16-1:0] err_count_in,         // Error counts, channel 0 lowest
	input  wire logic [11:0]              pos_peak_in,          // Running positive peak
	input  wire logic [11:0]              neg_peak_in,          // Running negative peak
	output logic                          bandwidth_select_out, // Bandwidth select to front end
	output logic                          period_select_out,    // 1: automatic periods
	output logic                          round_restart_out     // Pulse: start a new round
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int NCH = NUM_CH + 1;

	logic [2:0]  cfg;
	logic [2:0]  next_cfg;
	logic [15:0] err_snap      [0:NCH-1];
	logic [15:0] next_err_snap [0:NCH-1];
	logic [7:0]  rdata;
	logic [7:0]  next_rdata;
	logic        bw_q;
	logic        next_bw_q;
	logic        md_q;
	logic        next_md_q;
	logic        restart_q;
	logic        next_restart_q;
	logic [5:0]  err_l_hit;
	logic [5:0]  err_h_hit;
	logic [11:0] pos_result;
	logic [11:0] neg_result;

	jmr_cap_if cap ();

	// ----------------------------------------
	// Address decoding
	// ----------------------------------------
	// Returns {hit, channel} for an error count byte at the given page offset
	function automatic logic [5:0] jmr_err_decode(
		input logic [JMR_ADDR_W-1:0] addr,
		input logic [5:0]            ofs
	);
		logic [4:0] page;
		logic [5:0] result;
		page   = addr[10:6];
		result = 6'h00;
		if (addr[5:0] == ofs) begin
			if (page == JMR_CH0_PAGE) begin
				result = 6'h20;
			end else if (32'(page) < NUM_CH) begin
				result = {1'b1, page + 5'h01};
			end
		end
		return result;
	endfunction

	assign err_l_hit = jmr_err_decode(addr_in, JMR_ERR_L_OFS);
	assign err_h_hit = jmr_err_decode(addr_in, JMR_ERR_H_OFS);

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	// Only the three defined bits are stored; reserved bits are dropped
	always_comb begin
		next_cfg = cfg;
		if (ce_in && wr_in && (addr_in == JMR_CFG_ADDR)) begin
			next_cfg = wdata_in[2:0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg <= JMR_CFG_RESET;
		end else begin
			cfg <= next_cfg;
		end
	end

	// ----------------------------------------
	// Error count snapshots
	// ----------------------------------------
	// Counts are sampled each enabled cycle so they read zero until the first sample
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_err
			always_comb begin
				next_err_snap[gi] = err_snap[gi];
				if (ce_in) begin
					next_err_snap[gi] = err_count_in[gi*16 +: 16];
				end
			end

			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					err_snap[gi] <= JMR_ERR_RESET;
				end else begin
					err_snap[gi] <= next_err_snap[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Peak capture unit
	// ----------------------------------------
	assign cap.ce            = ce_in;
	assign cap.period_select = cfg[JMR_MD_BIT];
	assign cap.stop          = cfg[JMR_STOP_BIT];
	assign cap.pos_peak      = pos_peak_in;
	assign cap.neg_peak      = neg_peak_in;
	assign pos_result        = cap.pos_result;
	assign neg_result        = cap.neg_result;

	jmr_capture #(
		.AUTO_CYCLES (AUTO_CYCLES)
	) u_capture (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.cap    (cap)
	);

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Data stand for the one enabled cycle after the strobe and hold while ce_in is low, zero otherwise
	always_comb begin
		next_rdata = rdata;
		if (ce_in) begin
			next_rdata = JMR_RD_IDLE;
			if (rd_in) begin
				if (err_h_hit[5]) begin
					next_rdata = err_snap[err_h_hit[4:0]][15:8];
				end else if (err_l_hit[5]) begin
					next_rdata = err_snap[err_l_hit[4:0]][7:0];
				end else begin
					unique case (addr_in)
						JMR_CFG_ADDR:   next_rdata = {5'h00, cfg};
						JMR_POS_L_ADDR: next_rdata = pos_result[7:0];
						JMR_POS_H_ADDR: next_rdata = {4'h0, pos_result[11:8]};
						JMR_NEG_L_ADDR: next_rdata = neg_result[7:0];
						JMR_NEG_H_ADDR: next_rdata = {4'h0, neg_result[11:8]};
						default:        next_rdata = JMR_RD_IDLE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata <= JMR_RD_IDLE;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// Front end controls
	// ----------------------------------------
	// Registered copies of mode bits and the round restart pulse
	always_comb begin
		next_bw_q      = bw_q;
		next_md_q      = md_q;
		next_restart_q = restart_q;
		if (ce_in) begin
			next_bw_q      = cfg[JMR_BW_BIT];
			next_md_q      = cfg[JMR_MD_BIT];
			next_restart_q = cap.capture;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			bw_q      <= 1'b0;
			md_q      <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			bw_q      <= next_bw_q;
			md_q      <= next_md_q;
			restart_q <= next_restart_q;
		end
	end

	assign rdata_out            = rdata;
	assign bandwidth_select_out = bw_q;
	assign period_select_out    = md_q;
	assign round_restart_out    = restart_q;

endmodule

/* File: logic/jmr_pkg.sv */
package jmr_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int          JMR_ADDR_W     = 11;
	localparam logic [10:0] JMR_CFG_ADDR   = 11'h7E5; // Jitter measure config
	localparam logic [10:0] JMR_POS_L_ADDR = 11'h7E6; // Positive peak low byte
	localparam logic [10:0] JMR_POS_H_ADDR = 11'h7E7; // Positive peak high nibble
	localparam logic [10:0] JMR_NEG_L_ADDR = 11'h7E8; // Negative peak low byte
	localparam logic [10:0] JMR_NEG_H_ADDR = 11'h7E9; // Negative peak high nibble

	// Per-channel error count bytes, one page of 0x40 per channel
	localparam logic [5:0]  JMR_ERR_L_OFS  = 6'h23;   // Low byte offset in page
	localparam logic [5:0]  JMR_ERR_H_OFS  = 6'h24;   // High byte offset in page
	localparam logic [4:0]  JMR_CH0_PAGE   = 5'h1F;   // Page of reference channel

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int          JMR_BW_BIT     = 0;       // Bandwidth select
	localparam int          JMR_MD_BIT     = 1;       // Period select
	localparam int          JMR_STOP_BIT   = 2;       // Period stop
	localparam logic [2:0]  JMR_CFG_RESET  = 3'h0;
	localparam logic [11:0] JMR_PEAK_RESET = 12'h000;
	localparam logic [15:0] JMR_ERR_RESET  = 16'h0000;
	localparam logic [7:0]  JMR_RD_IDLE    = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned JMR_CLK_KHZ       = 20000; // 20 MHz system clock
	localparam int unsigned JMR_AUTO_PER_MS   = 1000;  // Automatic period in ms
	localparam int unsigned JMR_AUTO_CYCLES   = JMR_AUTO_PER_MS * JMR_CLK_KHZ;

endpackage

/* File: logic/jmr_cap_if.sv */
`timescale 1ns/1ps
// Link between the register bank and the peak capture unit
interface jmr_cap_if;
	logic        ce;            // Clock enable
	logic        period_select; // 1: automatic period
	logic        stop;          // Stop bit as written
	logic [11:0] pos_peak;      // Running positive peak
	logic [11:0] neg_peak;      // Running negative peak
	logic        capture;       // End of round, results loaded
	logic [11:0] pos_result;    // Held positive peak
	logic [11:0] neg_result;    // Held negative peak

	modport bank (
		output ce, period_select, stop, pos_peak, neg_peak,
		input  capture, pos_result, neg_result
	);
	modport unit (
		input  ce, period_select, stop, pos_peak, neg_peak,
		output capture, pos_result, neg_result
	);
endinterface

/* File: logic/jmr_capture.sv */
`timescale 1ns/1ps
module jmr_capture
	import jmr_pkg::*;
#(
	parameter int unsigned AUTO_CYCLES = JMR_AUTO_CYCLES // Cycles per automatic period
) (
	input  wire logic clk_in, // System clock
	input  wire logic rst_in, // Asynchronous reset, high
	jmr_cap_if.unit   cap     // Link to the register bank
);

	localparam int TMR_W = (AUTO_CYCLES > 1) ? $clog2(AUTO_CYCLES) : 1;
	localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(AUTO_CYCLES - 1);

	logic [TMR_W-1:0] timer;
	logic [TMR_W-1:0] next_timer;
	logic             stop_prev;
	logic             next_stop_prev;
	logic [11:0]      pos_hold;
	logic [11:0]      next_pos_hold;
	logic [11:0]      neg_hold;
	logic [11:0]      next_neg_hold;
	logic             manual_end;
	logic             auto_end;

	// ----------------------------------------
	// End of measurement round
	// ----------------------------------------
	// Manual end on a rising stop bit, automatic end on timer wrap
	assign manual_end  = !cap.period_select && cap.stop && !stop_prev;
	assign auto_end    = cap.period_select && (timer == TMR_LAST);
	assign cap.capture = cap.ce && (manual_end || auto_end);

	// Timer runs only in automatic mode, restarts from zero on entry
	always_comb begin
		next_timer     = timer;
		next_stop_prev = stop_prev;
		if (cap.ce) begin
			next_stop_prev = cap.stop;
			if (!cap.period_select || auto_end) begin
				next_timer = '0;
			end else begin
				next_timer = timer + TMR_W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			timer     <= '0;
			stop_prev <= 1'b0;
		end else begin
			timer     <= next_timer;
			stop_prev <= next_stop_prev;
		end
	end

	// ----------------------------------------
	// Result registers
	// ----------------------------------------
	// Both peaks load together, overwriting the previous round
	always_comb begin
		next_pos_hold = pos_hold;
		next_neg_hold = neg_hold;
		if (cap.capture) begin
			next_pos_hold = cap.pos_peak;
			next_neg_hold = cap.neg_peak;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pos_hold <= JMR_PEAK_RESET;
			neg_hold <= JMR_PEAK_RESET;
		end else begin
			pos_hold <= next_pos_hold;
			neg_hold <= next_neg_hold;
		end
	end

	assign cap.pos_result = pos_hold;
	assign cap.neg_result = neg_hold;

endmodule

/* File: tb/jmr_bank_checker.sv */
`timescale 1ns/1ps
module jmr_bank_checker
	import jmr_pkg::*;
#(
	parameter int          NUM_CH      = 16, // Line channels
	parameter int unsigned AUTO_CYCLES = 20  // Cycles per automatic round
) (
	input wire logic                     clk_in,               // Clock
	input wire logic                     rst_in,               // Reset
	input wire logic                     ce_in,                // Enable
	input wire logic [JMR_ADDR_W-1:0]    addr_in,              // Address
	input wire logic [7:0]               wdata_in,             // Write data
	input wire logic                     wr_in,                // Write strobe
	input wire logic                     rd_in,                // Read strobe
	input wire logic [7:0]               rdata_out,            // Read data
	input wire logic [(NUM_CH+1)*16-1:0] err_count_in,         // Error counts
	input wire logic [11:0]              pos_peak_in,          // Positive peak
	input wire logic [11:0]              neg_peak_in,          // Negative peak
	input wire logic                     bandwidth_select_out, // Bandwidth
	input wire logic                     period_select_out,    // Period mode
	input wire logic                     round_restart_out     // Restart pulse
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic        stop_wr;
	logic [7:0]  err0_hi;
	logic [31:0] gap;
	logic [31:0] next_gap;
	logic        auto_seen;
	logic        next_auto_seen;

	// Decoded bus events
	assign stop_wr = ce_in && wr_in && addr_in == JMR_CFG_ADDR && wdata_in[JMR_STOP_BIT];
	assign err0_hi = err_count_in[15:8];

	// Cycles since last restart, and auto mode seen at a restart
	always_comb begin
		next_gap       = round_restart_out ? 32'h1 : gap + 32'h1;
		next_auto_seen = period_select_out && (round_restart_out || auto_seen);
	end

	// Helper registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gap       <= 32'h0;
			auto_seen <= 1'b0;
		end else if (ce_in) begin
			gap       <= next_gap;
			auto_seen <= next_auto_seen;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_rd(logic [10:0] a);
		ce_in && rd_in && addr_in == a;
	endsequence
	sequence s_cfg_wr;
		ce_in && wr_in && addr_in == JMR_CFG_ADDR ##1 ce_in ##1 ce_in;
	endsequence

	AST_RD_IDLE: assert property (ce_in && !rd_in |=> rdata_out == JMR_RD_IDLE)
		else $error("read data not idle");
	AST_CFG_RSV: assert property (s_rd(JMR_CFG_ADDR) |=> rdata_out[7:3] == 5'h00)
		else $error("config reserved bits set");
	AST_PH_RSV: assert property (s_rd(JMR_POS_H_ADDR) |=> rdata_out[7:4] == 4'h0)
		else $error("peak high upper bits set");
	AST_ERR_HI: assert property (s_rd(11'h7E4) ##0 $past(ce_in) |=> rdata_out == $past(err0_hi, 2))
		else $error("error high byte wrong");
	AST_BW: assert property (s_cfg_wr |-> bandwidth_select_out == $past(wdata_in[0], 2))
		else $error("bandwidth select wrong");
	AST_MD: assert property (s_cfg_wr |-> period_select_out == $past(wdata_in[1], 2))
		else $error("period select wrong");
	AST_MAN_RESTART: assert property ($rose(round_restart_out) && !period_select_out
		&& !$past(period_select_out) && !$past(period_select_out, 3) |-> $past(stop_wr, 2))
		else $error("manual round without stop write");
	AST_PULSE: assert property (round_restart_out && ce_in |=> !round_restart_out)
		else $error("restart longer than one cycle");
	AST_AUTO_GAP: assert property (round_restart_out && auto_seen |-> gap == AUTO_CYCLES)
		else $error("automatic round length wrong");
endmodule

bind jmr_bank jmr_bank_checker #(.NUM_CH(NUM_CH), .AUTO_CYCLES(AUTO_CYCLES)) jmr_bank_checker_i (
	.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .err_count_in(err_count_in),
	.pos_peak_in(pos_peak_in), .neg_peak_in(neg_peak_in),
	.bandwidth_select_out(bandwidth_select_out), .period_select_out(period_select_out),
	.round_restart_out(round_restart_out));

/* File: tb/jmr_bank_test.sv */
`timescale 1ns/1ps
module jmr_bank_test;
	import jmr_pkg::*;
	localparam int          NCH  = 16;
	localparam int unsigned AUTO = 20;

	logic                  clk_in       = 1'b0;
	logic                  rst_in       = 1'b1;
	logic                  ce_in        = 1'b1;
	logic                  wr_in        = 1'b0;
	logic                  rd_in        = 1'b0;
	logic [10:0]           addr_in      = 11'h000;
	logic [7:0]            wdata_in     = 8'h00;
	logic [(NCH+1)*16-1:0] err_count_in = '0;
	logic [11:0]           pos_peak_in  = 12'h000;
	logic [11:0]           neg_peak_in  = 12'h000;
	logic [7:0]            rdata_out;
	logic                  bw_out;
	logic                  md_out;
	logic                  restart_out;
	int                    miscompares  = 0;
	int                    checked      = 0;
	int                    cycles       = 0;
	int                    restarts     = 0;

	// ----------------------------------------
	// Clock, design, watchdog
	// ----------------------------------------
	always #25 clk_in = ~clk_in;

	jmr_bank #(.NUM_CH(NCH), .AUTO_CYCLES(AUTO)) jmr_bank_i (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.err_count_in(err_count_in), .pos_peak_in(pos_peak_in), .neg_peak_in(neg_peak_in),
		.bandwidth_select_out(bw_out), .period_select_out(md_out),
		.round_restart_out(restart_out));

	// Cycle and restart counting, hang cut-off
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (restart_out === 1'b1) begin
			restarts <= restarts + 1;
		end
		if (cycles == 2000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic reg_wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	task automatic reg_rd(input logic [10:0] a, input logic [7:0] exp, input string name);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(name, {4'h0, exp}, {4'h0, rdata_out});
	endtask

	task automatic wrap_up();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int n;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		reg_rd(11'h7E4, 8'h00, "err0_hi");
		reg_rd(JMR_CFG_ADDR, 8'h00, "cfg");
		@(posedge clk_in);
		for (int c = 0; c <= NCH; c++) begin
			err_count_in[c*16 +: 16] <= {8'(c) ^ 8'hA5, 8'(c)};
		end
		for (int c = 1; c <= NCH; c++) begin
			reg_rd(11'h024 + 11'((c - 1) << 6), 8'(c) ^ 8'hA5, "err_hi");
		end
		reg_rd(11'h7E4, 8'hA5, "err0_hi");
		reg_rd(11'h7E3, 8'h00, "err0_lo");
		reg_rd(11'h7FF, 8'h00, "unmapped");
		reg_wr(JMR_POS_L_ADDR, 8'hFF);
		reg_rd(JMR_POS_L_ADDR, 8'h00, "pos_lo");
		reg_wr(JMR_CFG_ADDR, 8'hF9);
		reg_rd(JMR_CFG_ADDR, 8'h01, "cfg");
		chk("bw", 12'h001, {11'h000, bw_out});
		chk("md", 12'h000, {11'h000, md_out});
		reg_wr(JMR_CFG_ADDR, 8'h02);
		reg_rd(JMR_CFG_ADDR, 8'h02, "cfg");
		chk("bw", 12'h000, {11'h000, bw_out});
		chk("md", 12'h001, {11'h000, md_out});
		reg_wr(JMR_CFG_ADDR, 8'h00);
		// Manual round ended by the stop bit
		pos_peak_in <= 12'hABC;
		neg_peak_in <= 12'h5D3;
		repeat (4) @(posedge clk_in);
		n = restarts;
		reg_wr(JMR_CFG_ADDR, 8'h04);
		reg_rd(JMR_POS_L_ADDR, 8'hBC, "pos_lo");
		reg_rd(JMR_POS_H_ADDR, 8'h0A, "pos_hi");
		reg_rd(JMR_NEG_L_ADDR, 8'hD3, "neg_lo");
		reg_rd(JMR_NEG_H_ADDR, 8'h05, "neg_hi");
		chk("rounds", 12'h001, 12'(restarts - n));
		@(posedge clk_in);
		pos_peak_in <= 12'h123;
		neg_peak_in <= 12'h456;
		reg_wr(JMR_CFG_ADDR, 8'h04);
		reg_rd(JMR_POS_L_ADDR, 8'hBC, "pos_lo");
		reg_wr(JMR_CFG_ADDR, 8'h00);
		reg_wr(JMR_CFG_ADDR, 8'h04);
		reg_rd(JMR_POS_L_ADDR, 8'h23, "pos_lo");
		reg_rd(JMR_NEG_H_ADDR, 8'h04, "neg_hi");
		// Automatic rounds, stop bit ignored
		@(posedge clk_in);
		pos_peak_in <= 12'h7F1;
		n = restarts;
		reg_wr(JMR_CFG_ADDR, 8'h06);
		repeat (3 * AUTO) @(posedge clk_in);
		reg_rd(JMR_POS_L_ADDR, 8'hF1, "pos_lo");
		reg_rd(JMR_POS_H_ADDR, 8'h07, "pos_hi");
		chk("auto_rounds", 12'h001, {11'h000, restarts - n >= 2});
		reg_wr(JMR_CFG_ADDR, 8'h00);
		repeat (4) @(posedge clk_in);
		// Frozen while disabled
		ce_in <= 1'b0;
		reg_wr(JMR_CFG_ADDR, 8'h01);
		ce_in <= 1'b1;
		reg_rd(JMR_CFG_ADDR, 8'h00, "cfg");
		wrap_up();
	end
endmodule
